// *** scr_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts for the supply control registers
// Assumes: 100 MHz system clock, 8-bit register data
// Notes:   Definitions only
//
// Notes on behaviour
// - Reference state read-only; writable only in test mode
// - RTC regulator state: 01 active, 11 sleep
// - Keep-full-load bit holds RTC regulator full when off
// - Backup supply forces RTC regulator low power
// - I/O current limit 0.6/1.0/1.3/1.3 A, reset 00
// - I/O voltage bits 3:2 select 1.5/1.8/2.5/3.3 V
// - I/O state: 00,10 off; 01 active; 11 sleep
// - Core gain bits 7:6: x1,x1,x2,x3
// - Core voltage ramps 12.5 mV steps; 000 bypasses
// - Step rate fractions of 3 MHz; reset 011
// - Core state: 00,10 off; 01 high; 11 low, reset 00
// - RTC regulator register cleared by general reset only
// - Other three registers cleared by turn-off reset
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SCR_OFS_REF        8'h1d
`define SCR_OFS_RTC        8'h1e
`define SCR_OFS_IO         8'h20
`define SCR_OFS_CORE1      8'h21

// ****************************************
// Field positions and writable masks
// ****************************************
`define SCR_ST_LSB         0
`define SCR_RTC_KEEP_BIT   3
`define SCR_IO_SEL_LSB     2
`define SCR_IO_ILIM_LSB    6
`define SCR_C1_RAMP_STEP_TIME_LSB   2
`define SCR_C1_ILIM_BIT    5
`define SCR_C1_GAIN_LSB    6
`define SCR_REF_WMASK      8'h03
`define SCR_RTC_WMASK      8'h08
`define SCR_RTC_TMASK      8'h0b
`define SCR_IO_WMASK       8'hcf
`define SCR_C1_WMASK       8'hff

// ****************************************
// Reset values
// ****************************************
`define SCR_RST_REF        2'h1
`define SCR_RST_RTC_ST     2'h1
`define SCR_RST_IO_ST      2'h0
`define SCR_RST_IO_ILIM    2'h0
`define SCR_RST_C1_ST      2'h0
`define SCR_RST_C1_RAMP_STEP_TIME   3'h3
`define SCR_RST_C1_ILIM    1'b0

// ****************************************
// Supply state codes
// ****************************************
`define SCR_ST_OFF         2'h0
`define SCR_ST_ACTIVE      2'h1
`define SCR_ST_SLEEP       2'h3

// ****************************************
// Ramp timing: base sampling 3 MHz from 100 MHz
// ****************************************
`define SCR_CLK_MHZ        100
`define SCR_RAMP_BASE_MHZ  3
`define SCR_RAMP_BASE_CYC  (`SCR_CLK_MHZ / `SCR_RAMP_BASE_MHZ)
`define SCR_RAMP_STEP_UV   12500

`endif

// *** scr_pkg.sv ***
// Purpose: Types for the supply control register slice
// Assumes: Constants come from scr_consts.svh
// Notes:   Types only
package scr_pkg;

   // Ramp sequencer states, Gray order along idle->wait->step
   typedef enum logic [1:0]
   {
      SCR_RAMP_IDLE = 2'b00,
      SCR_RAMP_WAIT = 2'b01,
      SCR_RAMP_STEP = 2'b11
   } scr_ramp_e;

   typedef logic [7:0] scr_byte_t;  // Register data
   typedef logic [6:0] scr_vsel_t;  // Core voltage code

endpackage : scr_pkg

// *** scr_ramp_if.sv ***
// Purpose: Links the register bank to the core converter ramp engine
// Assumes: Single clock domain
// Notes:   Register side drives settings, ramp side reports output
interface scr_ramp_if;
   import scr_pkg::*;
   logic [2:0] step_time;   // Step time code
   scr_vsel_t  target;      // Requested voltage code
   logic       clear;       // Turn-off reset of the ramp
   scr_vsel_t  applied;     // Code presently applied
   logic       busy;        // Ramp in progress

   modport regs (output step_time, output target, output clear, input applied, input busy);
   modport ramp (input step_time, input target, input clear, output applied, output busy);
endinterface : scr_ramp_if

// *** scr_ramp.sv ***
// Purpose: Moves the core converter code toward target one step at a time
// Assumes: One code per 12.5 mV step
// Notes:   Step interval derives from a 3 MHz base divided per step-time code
`include "scr_consts.svh"
module scr_ramp
   import scr_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // Register side
   scr_ramp_if.ramp  rif
);

   // ****************************************
   // Interval per step-time code
   // ****************************************
   // Period in base cycles times divider: 3/4 rate etc. kept as ratio num/den
   function automatic logic [7:0] step_cycles(input logic [2:0] code);
      begin
         case (code)
            3'h1:    step_cycles = 8'(`SCR_RAMP_BASE_CYC);          // 3 MHz
            3'h2:    step_cycles = 8'((`SCR_RAMP_BASE_CYC * 4) / 3);  // x3/4
            3'h3:    step_cycles = 8'((`SCR_RAMP_BASE_CYC * 5) / 3);  // x3/5
            3'h4:    step_cycles = 8'(`SCR_RAMP_BASE_CYC * 2);       // /2
            3'h5:    step_cycles = 8'(`SCR_RAMP_BASE_CYC * 3);       // /3
            3'h6:    step_cycles = 8'(`SCR_RAMP_BASE_CYC * 4);       // /4
            default: step_cycles = 8'(`SCR_RAMP_BASE_CYC * 5);       // /5
         endcase
      end
   endfunction : step_cycles

   scr_ramp_e  state_ff;   // Sequencer state
   logic [7:0] cnt_ff;     // Interval counter
   scr_vsel_t  out_ff;     // Applied code

   assign rif.applied = out_ff;
   assign rif.busy    = (state_ff != SCR_RAMP_IDLE);

   // ****************************************
   // Sequencer
   // ****************************************
   // Bypass (000) jumps straight to target; otherwise one code per interval
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || rif.clear)
      begin
         state_ff <= SCR_RAMP_IDLE;
         cnt_ff   <= 8'h00;
         out_ff   <= 7'h00;
      end
      else if (rif.step_time == 3'h0)
      begin
         state_ff <= SCR_RAMP_IDLE;
         out_ff   <= rif.target;
      end
      else
      begin
         case (state_ff)
            SCR_RAMP_IDLE:
            begin
               if (out_ff != rif.target)
               begin
                  state_ff <= SCR_RAMP_WAIT;
                  cnt_ff   <= step_cycles(rif.step_time) - 8'h01;
               end
            end
            SCR_RAMP_WAIT:
            begin
               // Rate changes take effect at the next interval reload
               if (cnt_ff == 8'h00)
               begin
                  state_ff <= SCR_RAMP_STEP;
               end
               else
               begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            SCR_RAMP_STEP:
            begin
               // One 12.5 mV step toward target, either direction
               if (out_ff < rif.target)
               begin
                  out_ff <= out_ff + 7'h01;
               end
               else if (out_ff > rif.target)
               begin
                  out_ff <= out_ff - 7'h01;
               end
               state_ff <= SCR_RAMP_IDLE;
            end
            default: state_ff <= SCR_RAMP_IDLE;
         endcase
      end
   end

endmodule : scr_ramp

// *** scr_regs.sv ***
// Purpose: Supply control register slice: reference, RTC regulator, I/O and core converters
// Assumes: Byte-wide register port from the control serial interface, one access per strobe
// Notes:   Two reset domains: general reset and turn-off reset
`include "scr_consts.svh"
module scr_regs
   import scr_pkg::*;
(
   // Clock and resets
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,            // General reset
   input  wire logic       turnoff_rst_i,    // Turn-off reset domain event
   // Register access from the control serial interface
   input  wire logic       reg_wr_i,         // Write strobe
   input  wire logic       reg_rd_i,         // Read strobe
   input  wire logic [7:0] reg_addr_i,       // Register offset
   input  wire scr_pkg::scr_byte_t reg_wdata_i,
   output logic [7:0]      reg_rdata_o,      // Read data, one cycle after strobe
   output logic            reg_hit_o,        // Offset belongs to this slice
   // Device conditions
   input  wire logic       test_mode_i,      // Test mode unlocks reference and RTC state fields
   input  wire logic       dev_off_i,        // Device in off state (pin)
   input  wire logic       on_backup_i,      // Running from backup supply (pin)
   input  wire logic [1:0] boot_io_sel_i,    // Boot configuration I/O voltage
   input  wire logic [1:0] boot_gain_i,      // Boot configuration core gain
   input  wire logic       boot_keep_i,      // Boot configuration keep-full-load
   input  wire scr_pkg::scr_vsel_t core1_target_i, // Core voltage code from voltage registers
   // Analog controls
   output logic [1:0]      ref_state_o,      // Reference state
   output logic            rtc_full_load_o,  // RTC regulator at full load
   output logic [1:0]      rtc_state_o,      // RTC regulator state
   output logic [1:0]      io_state_o,       // I/O converter state
   output logic            io_enable_o,      // I/O converter on
   output logic            io_low_power_o,   // I/O converter sleep
   output logic [1:0]      io_vsel_o,        // I/O voltage code
   output logic [1:0]      io_ilim_o,        // I/O current limit code, 10 and 11 merged
   output logic            core1_enable_o,   // Core converter on
   output logic            core1_low_power_o,// Core converter low power
   output logic [1:0]      core1_gain_o,     // Gain multiplier 1..3
   output logic            core1_ilim_o,     // Core current limit
   output scr_pkg::scr_vsel_t core1_vsel_o,  // Ramped voltage code
   output logic            core1_busy_o      // Ramp in progress
);
   import scr_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   logic [1:0] ref_st_ff;       // Reference state
   logic [1:0] rtc_st_ff;       // RTC regulator state
   logic       rtc_keep_ff;     // Keep-full-load when off
   logic [1:0] io_ilim_ff;      // I/O current limit
   logic [1:0] io_sel_ff;       // I/O voltage select
   logic [1:0] io_st_ff;        // I/O state
   logic [1:0] c1_gain_ff;      // Core gain field
   logic       c1_ilim_ff;      // Core current limit
   logic [2:0] c1_ramp_step_time_ff;     // Core step time
   logic [1:0] c1_st_ff;        // Core state
   logic       boot_ld_ff;      // Boot straps pending capture
   logic       boot_gen_ff;     // Keep strap pending, general reset only
   logic [2:0] off_sync_ff;     // Device-off pin synchroniser
   logic [2:0] bck_sync_ff;     // Backup pin synchroniser
   logic       dev_off_ff;      // Filtered device-off
   logic       on_bck_ff;       // Filtered backup

   scr_ramp_if rif ();

   // Writes decoded per register
   logic wr_ref;
   logic wr_rtc;
   logic wr_io;
   logic wr_c1;
   assign wr_ref = reg_wr_i && (reg_addr_i == `SCR_OFS_REF);
   assign wr_rtc = reg_wr_i && (reg_addr_i == `SCR_OFS_RTC);
   assign wr_io  = reg_wr_i && (reg_addr_i == `SCR_OFS_IO);
   assign wr_c1  = reg_wr_i && (reg_addr_i == `SCR_OFS_CORE1);

   // Map a state code to on / low-power; 00 and 10 both mean off
   function automatic logic st_on(input logic [1:0] st);
      begin
         st_on = st[0];
      end
   endfunction : st_on

   function automatic logic st_low(input logic [1:0] st);
      begin
         st_low = (st == `SCR_ST_SLEEP);
      end
   endfunction : st_low

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Change accepted only when second and third stages agree
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         off_sync_ff <= 3'h0;
         bck_sync_ff <= 3'h0;
         dev_off_ff  <= 1'b0;
         on_bck_ff   <= 1'b0;
      end
      else
      begin
         off_sync_ff <= {off_sync_ff[1:0], dev_off_i};
         bck_sync_ff <= {bck_sync_ff[1:0], on_backup_i};
         if (off_sync_ff[2] == off_sync_ff[1])
         begin
            dev_off_ff <= off_sync_ff[2];
         end
         if (bck_sync_ff[2] == bck_sync_ff[1])
         begin
            on_bck_ff <= bck_sync_ff[2];
         end
      end
   end

   // ****************************************
   // Boot capture flag
   // ****************************************
   // I/O voltage and gain straps are caught on the first clocked edge after either reset; the keep strap only after general reset
   always_ff @(posedge clk_sys_i)
   begin
      boot_gen_ff <= rst_i;
      if (rst_i || turnoff_rst_i)
      begin
         boot_ld_ff <= 1'b1;
      end
      else
      begin
         boot_ld_ff <= 1'b0;
      end
   end

   // ****************************************
   // Reference state register
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || turnoff_rst_i)
      begin
         ref_st_ff <= `SCR_RST_REF;
      end
      else if (wr_ref && test_mode_i)
      begin
         ref_st_ff <= reg_wdata_i[1:0];
      end
   end

   // ****************************************
   // RTC regulator register (general reset only)
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rtc_st_ff   <= `SCR_RST_RTC_ST;
         rtc_keep_ff <= 1'b0;
      end
      else
      begin
         // A turn-off reset must not reload the keep bit
         if (boot_gen_ff)
         begin
            rtc_keep_ff <= boot_keep_i;
         end
         else if (wr_rtc)
         begin
            rtc_keep_ff <= reg_wdata_i[`SCR_RTC_KEEP_BIT];
         end
         // State field writable in test mode only; reserved codes rejected
         if (wr_rtc && test_mode_i && reg_wdata_i[0])
         begin
            rtc_st_ff <= reg_wdata_i[1:0];
         end
      end
   end

   // ****************************************
   // I/O converter register
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || turnoff_rst_i)
      begin
         io_ilim_ff <= `SCR_RST_IO_ILIM;
         io_st_ff   <= `SCR_RST_IO_ST;
         io_sel_ff  <= 2'h0;
      end
      else if (boot_ld_ff)
      begin
         io_sel_ff <= boot_io_sel_i;
      end
      else if (wr_io)
      begin
         io_ilim_ff <= reg_wdata_i[`SCR_IO_ILIM_LSB +: 2];
         io_sel_ff  <= reg_wdata_i[`SCR_IO_SEL_LSB +: 2];
         io_st_ff   <= reg_wdata_i[`SCR_ST_LSB +: 2];
      end
   end

   // ****************************************
   // Core converter control register
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || turnoff_rst_i)
      begin
         c1_gain_ff  <= 2'h0;
         c1_ilim_ff  <= `SCR_RST_C1_ILIM;
         c1_ramp_step_time_ff <= `SCR_RST_C1_RAMP_STEP_TIME;
         c1_st_ff    <= `SCR_RST_C1_ST;
      end
      else if (boot_ld_ff)
      begin
         c1_gain_ff <= boot_gain_i;
      end
      else if (wr_c1)
      begin
         c1_gain_ff  <= reg_wdata_i[`SCR_C1_GAIN_LSB +: 2];
         c1_ilim_ff  <= reg_wdata_i[`SCR_C1_ILIM_BIT];
         c1_ramp_step_time_ff <= reg_wdata_i[`SCR_C1_RAMP_STEP_TIME_LSB +: 3];
         c1_st_ff    <= reg_wdata_i[`SCR_ST_LSB +: 2];
      end
   end

   // ****************************************
   // Ramp engine
   // ****************************************
   assign rif.step_time = c1_ramp_step_time_ff;
   assign rif.target    = core1_target_i;
   assign rif.clear     = turnoff_rst_i;

   scr_ramp u_ramp
   (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .rif       (rif)
   );

   // ****************************************
   // Read-back
   // ****************************************
   // Reserved bits return zero; unmapped offsets read zero with hit low
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= 8'h00;
         reg_hit_o   <= 1'b0;
      end
      else if (reg_rd_i)
      begin
         reg_hit_o <= 1'b1;
         case (reg_addr_i)
            `SCR_OFS_REF:   reg_rdata_o <= {6'h00, ref_st_ff};
            `SCR_OFS_RTC:   reg_rdata_o <= {4'h0, rtc_keep_ff, 1'b0, rtc_st_ff};
            `SCR_OFS_IO:    reg_rdata_o <= {io_ilim_ff, 2'h0, io_sel_ff, io_st_ff};
            `SCR_OFS_CORE1: reg_rdata_o <= {c1_gain_ff, c1_ilim_ff, c1_ramp_step_time_ff, c1_st_ff};
            default:
            begin
               reg_rdata_o <= 8'h00;
               reg_hit_o   <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Analog control outputs
   // ****************************************
   // All registered so the analog side never sees decode glitches
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ref_state_o       <= `SCR_RST_REF;
         rtc_full_load_o   <= 1'b1;
         rtc_state_o       <= `SCR_RST_RTC_ST;
         io_state_o        <= `SCR_ST_OFF;
         io_enable_o       <= 1'b0;
         io_low_power_o    <= 1'b0;
         io_vsel_o         <= 2'h0;
         io_ilim_o         <= 2'h0;
         core1_enable_o    <= 1'b0;
         core1_low_power_o <= 1'b0;
         core1_gain_o      <= 2'h1;
         core1_ilim_o      <= 1'b0;
         core1_vsel_o      <= 7'h00;
         core1_busy_o      <= 1'b0;
      end
      else
      begin
         ref_state_o     <= ref_st_ff;
         rtc_state_o     <= rtc_st_ff;
         // Backup overrides keep bit; off drops unless kept
         rtc_full_load_o <= !on_bck_ff && (!dev_off_ff || rtc_keep_ff) && !st_low(rtc_st_ff);
         io_state_o      <= io_st_ff;
         io_enable_o     <= st_on(io_st_ff);
         io_low_power_o  <= st_low(io_st_ff);
         io_vsel_o       <= io_sel_ff;
         io_ilim_o       <= (io_ilim_ff[1]) ? 2'h2 : io_ilim_ff;
         core1_enable_o  <= st_on(c1_st_ff);
         core1_low_power_o <= st_low(c1_st_ff);
         core1_gain_o    <= (c1_gain_ff[1]) ? (c1_gain_ff[0] ? 2'h3 : 2'h2) : 2'h1;
         core1_ilim_o    <= c1_ilim_ff;
         core1_vsel_o    <= rif.applied;
         core1_busy_o    <= rif.busy;
      end
   end

endmodule : scr_regs

// *** scr_regs_monitor.sv ***
// Purpose: Concurrent checks on the supply control register slice ports
// Assumes: Controls lag register state by one cycle, read data by one
// Notes:   Bound to scr_regs below the module
module scr_regs_monitor
   import scr_pkg::*;
(
   // Clock and resets
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   input wire logic       turnoff_rst_i,
   // Register port
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire scr_pkg::scr_byte_t reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       reg_hit_o,
   // Conditions and controls
   input wire logic       test_mode_i,
   input wire logic       on_backup_i,
   input wire logic [1:0] ref_state_o,
   input wire logic       rtc_full_load_o,
   input wire logic [1:0] io_state_o,
   input wire logic       io_enable_o,
   input wire logic       io_low_power_o,
   input wire logic [1:0] io_vsel_o,
   input wire logic [1:0] io_ilim_o,
   input wire logic       core1_enable_o,
   input wire logic       core1_low_power_o,
   input wire logic [1:0] core1_gain_o,
   input wire logic       core1_ilim_o
);
   // ****************************************
   // Helper logic
   // ****************************************
   logic       mapped;      // Offset belongs to the slice
   logic [7:0] rsv_mask;    // Reserved bits of the addressed register
   scr_byte_t  wd_d1_ff;    // Write data one edge back
   scr_byte_t  wd_d2_ff;    // Write data two edges back
   assign mapped = reg_addr_i inside {8'h1d, 8'h1e, 8'h20, 8'h21};
   assign rsv_mask = (reg_addr_i == 8'h1d) ? 8'hfc : (reg_addr_i == 8'h1e) ? 8'hf4 : (reg_addr_i == 8'h20) ? 8'h30 : 8'h00;
   // Write data delayed to line up with the outputs
   always_ff @(posedge clk_sys_i)
   begin
      wd_d1_ff <= reg_wdata_i;
      wd_d2_ff <= wd_d1_ff;
   end
   // ****************************************
   // Assertions
   // ****************************************
   hit_decode_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i |=> reg_hit_o == $past(mapped)) else $error("read hit flag wrong");
   rsvd_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i && mapped |=> (reg_rdata_o & $past(rsv_mask)) == 8'h00) else $error("reserved bits not zero");
   io_decode_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      io_enable_o == io_state_o[0] && io_low_power_o == (io_state_o == 2'h3)) else $error("io state decode wrong");
   io_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || turnoff_rst_i)
      reg_wr_i && reg_addr_i == 8'h20 |-> ##2 io_state_o == wd_d2_ff[1:0] && io_vsel_o == wd_d2_ff[3:2]
      && io_ilim_o == (wd_d2_ff[7] ? 2'h2 : wd_d2_ff[7:6])) else $error("io controls wrong");
   core_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || turnoff_rst_i)
      reg_wr_i && reg_addr_i == 8'h21 |-> ##2 core1_enable_o == wd_d2_ff[0] && core1_ilim_o == wd_d2_ff[5]
      && core1_low_power_o == (wd_d2_ff[1:0] == 2'h3) && core1_gain_o == (wd_d2_ff[7] ? wd_d2_ff[7:6] : 2'h1))
      else $error("core controls wrong");
   ref_locked_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || turnoff_rst_i)
      reg_wr_i && reg_addr_i == 8'h1d && !test_mode_i |-> ##2 $stable(ref_state_o)) else $error("reference changed");
   backup_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      on_backup_i [*6] |-> !rtc_full_load_o) else $error("full load on backup");
   turnoff_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      turnoff_rst_i |-> ##2 io_state_o == 2'h0 && !core1_enable_o && ref_state_o == 2'h1)
      else $error("turn-off reset did not clear");
endmodule : scr_regs_monitor

bind scr_regs scr_regs_monitor i_mon (.*);

// *** test_supply_control_regs.sv ***
// Purpose: Directed bench for the supply control register slice
// Assumes: Inputs change at the falling edge; boot pins fixed (io 10, gain 10, keep 1)
// Notes:   Each scenario judges its own results
module test_supply_control_regs;
   import scr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Signals
   // ****************************************
   logic       clk_sys_i, rst_i, turnoff_rst_i, reg_wr_i, reg_rd_i, test_mode_i, dev_off_i, on_backup_i;
   logic [7:0] reg_addr_i, reg_rdata_o;
   scr_byte_t  reg_wdata_i;
   logic       reg_hit_o, boot_keep_i, rtc_full_load_o, io_enable_o, io_low_power_o;
   logic [1:0] boot_io_sel_i, boot_gain_i, ref_state_o, rtc_state_o, io_state_o, io_vsel_o, io_ilim_o;
   logic       core1_enable_o, core1_low_power_o, core1_ilim_o, core1_busy_o;
   logic [1:0] core1_gain_o;
   scr_vsel_t  core1_target_i, core1_vsel_o;
   int         err_count, cmp_count, cyc_count;

   scr_regs i_dut (.*);

   // Free-running 100 MHz clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard: the run takes about 1050 cycles
   always @(posedge clk_sys_i)
   begin
      cyc_count = cyc_count + 1;
      if (cyc_count == 3000)
      begin
         err_count = err_count + 1;
         summarize();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task summarize();
      if (err_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task nwait(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : nwait
   // One write strobe, dropped after the taking edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      chk("rdata", reg_rdata_o, exp);
   endtask : rd_chk
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset();
      rd_chk(8'h1d, 8'h01);
      rd_chk(8'h1e, 8'h09);
      rd_chk(8'h20, 8'h08);
      rd_chk(8'h21, 8'h8c);
      rd_chk(8'h1f, 8'h00);
      chk("hit", {7'h0, reg_hit_o}, 8'h00);
   endtask : t_reset
   task t_ref();
      wr(8'h1d, 8'h03);
      rd_chk(8'h1d, 8'h01);
      test_mode_i = 1'b1;
      wr(8'h1d, 8'hff);
      rd_chk(8'h1d, 8'h03);
      chk("ref_state", ref_state_o, 8'h03);
      wr(8'h1d, 8'h01);
      test_mode_i = 1'b0;
   endtask : t_ref
   task t_rtc();
      wr(8'h1e, 8'hf7);
      rd_chk(8'h1e, 8'h01);
      test_mode_i = 1'b1;
      wr(8'h1e, 8'h0b);
      rd_chk(8'h1e, 8'h0b);
      chk("rtc_state", rtc_state_o, 8'h03);
      chk("rtc_full", rtc_full_load_o, 8'h00);
      wr(8'h1e, 8'h0a);
      rd_chk(8'h1e, 8'h0b);
      wr(8'h1e, 8'h09);
      test_mode_i = 1'b0;
   endtask : t_rtc
   // Pins pass a synchroniser; allow settle time
   task t_full();
      dev_off_i = 1'b1;
      nwait(8);
      chk("rtc_full", rtc_full_load_o, 8'h01);
      wr(8'h1e, 8'h01);
      nwait(3);
      chk("rtc_full", rtc_full_load_o, 8'h00);
      dev_off_i = 1'b0;
      on_backup_i = 1'b1;
      wr(8'h1e, 8'h09);
      nwait(8);
      chk("rtc_full", rtc_full_load_o, 8'h00);
      on_backup_i = 1'b0;
      nwait(8);
      chk("rtc_full", rtc_full_load_o, 8'h01);
   endtask : t_full
   task t_io();
      logic [1:0] i;
      for (int k = 0; k < 4; k++)
      begin
         i = k[1:0];
         wr(8'h20, {i, 2'b11, i, i});
         rd_chk(8'h20, {i, 2'b00, i, i});
         chk("io_ilim", io_ilim_o, (i == 2'h3) ? 8'h02 : i);
         chk("io_vsel", io_vsel_o, i);
         chk("io_mode", {io_low_power_o, io_enable_o}, {i == 2'h3, i[0]});
      end
   endtask : t_io
   task t_core();
      logic [1:0] g;
      for (int k = 0; k < 4; k++)
      begin
         g = k[1:0];
         wr(8'h21, {g, 1'b1, 3'h3, g});
         rd_chk(8'h21, {g, 1'b1, 3'h3, g});
         chk("core_gain", core1_gain_o, g[1] ? g : 2'h1);
         chk("core_mode", {core1_low_power_o, core1_enable_o}, {g == 2'h3, g[0]});
      end
   endtask : t_core
   // Times a ramp to target against the step interval
   task ramp_run(input logic [2:0] code, input scr_vsel_t to, input int per);
      int n, cyc;
      scr_vsel_t s;
      s = core1_vsel_o;
      n = (to > s) ? to - s : s - to;
      wr(8'h21, {3'h2, code, 2'h1});
      core1_target_i = to;
      nwait(per / 2);
      chk("ramp_hold", core1_vsel_o, {1'b0, s});
      chk("ramp_busy", {7'h0, core1_busy_o}, 8'h01);
      cyc = per / 2;
      while (core1_vsel_o !== to && cyc < 2000)
      begin
         @(negedge clk_sys_i);
         cyc = cyc + 1;
      end
      chk("ramp_time", {7'h0, cyc >= n * per && cyc <= n * (per + 3) + 6}, 8'h01);
   endtask : ramp_run
   task t_ramp();
      wr(8'h21, 8'h41);
      core1_target_i = 7'h20;
      nwait(3);
      chk("bypass", core1_vsel_o, 8'h20);
      ramp_run(3'h1, 7'h24, 33);
      ramp_run(3'h7, 7'h22, 165);
      ramp_run(3'h2, 7'h23, 44);
      ramp_run(3'h3, 7'h22, 55);
      ramp_run(3'h4, 7'h23, 66);
      ramp_run(3'h5, 7'h22, 99);
      ramp_run(3'h6, 7'h23, 132);
   endtask : t_ramp
   task t_turnoff();
      test_mode_i = 1'b1;
      wr(8'h1e, 8'h03);
      test_mode_i = 1'b0;
      wr(8'h20, 8'hc1);
      turnoff_rst_i = 1'b1;
      nwait(2);
      turnoff_rst_i = 1'b0;
      nwait(2);
      rd_chk(8'h20, 8'h08);
      rd_chk(8'h21, 8'h8c);
      rd_chk(8'h1d, 8'h01);
      rd_chk(8'h1e, 8'h03);
      rst_i = 1'b1;
      nwait(8);
      rst_i = 1'b0;
      nwait(3);
      rd_chk(8'h1e, 8'h09);
   endtask : t_turnoff
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {err_count, cmp_count, cyc_count} = '0;
      {rst_i, turnoff_rst_i, reg_wr_i, reg_rd_i, test_mode_i, dev_off_i, on_backup_i} = 7'h40;
      {reg_addr_i, reg_wdata_i, core1_target_i} = '0;
      boot_io_sel_i = 2'h2;
      boot_gain_i = 2'h2;
      boot_keep_i = 1'b1;
      nwait(8);
      rst_i = 1'b0;
      nwait(3);
      t_reset();
      t_ref();
      t_rtc();
      t_full();
      t_io();
      t_core();
      t_ramp();
      t_turnoff();
      summarize();
   end
endmodule : test_supply_control_regs
